// ===== hdl/dmts_pkg.sv
/*
  Package for the drive mode block: register indices, field positions,
  mode codes, reset values and timing counts.
  Assumes a 250 MHz reference clock.
*/
package dmts_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CYCLE_BASE_US = 1000;
  localparam int CYCLE_BASE_CLKS = CYCLE_BASE_US * CLK_MHZ;
  localparam int INPUT_SAMPLE_US = 1000;
  localparam int INPUT_SAMPLE_CLKS = INPUT_SAMPLE_US * CLK_MHZ;
  localparam logic [15:0] REG_CONTROL = 16'h6040;
  localparam logic [15:0] REG_STATUS = 16'h6041;
  localparam logic [15:0] REG_INPUTS = 16'h60fd;
  localparam logic [15:0] REG_OUTPUTS = 16'h60fe;
  localparam logic [7:0] MODE_TORQUE = 8'h0a;
  localparam logic [7:0] MODE_STEPDIR = 8'hff;
  localparam logic [7:0] MODE_SETUP = 8'hfe;
  localparam int ST_SYNC_BIT = 8;
  localparam int ST_INDEX_BIT = 10;
  localparam int ST_FOLLOW_BIT = 12;
  localparam int ST_FERR_BIT = 13;
  localparam int CW_START_BIT = 4;
  localparam int LEVEL_BASE_BIT = 16;
  localparam int INTERP_INDEX_MS = -3;
  localparam logic [15:0] STEP_NUM_RST = 16'h0080;
  localparam logic [15:0] STEP_DEN_RST = 16'h0001;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
endpackage

// ===== hdl/dmts_top.sv
/*
  Operating-mode logic: cyclic torque, step/direction input, auto-setup,
  and the input/output summary words. Registers are reached by index over
  a simple word port. Pins are asynchronous; all but setup_done_in are synchronised here.
*/
`timescale 1ns/1ps
module dmts_top import dmts_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_idx_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Configuration objects
  input wire logic [7:0] mode_select_in,
  input wire logic closed_loop_in,
  input wire logic [15:0] target_torque_in,
  input wire logic target_torque_wr_in,
  input wire logic [15:0] max_torque_in,
  input wire logic [15:0] max_current_in,
  input wire logic [15:0] torque_offset_in,
  input wire logic [7:0] interp_period_in,
  input wire logic signed [7:0] interp_index_in,
  input wire logic [15:0] step_num_in,
  input wire logic [15:0] step_den_in,
  input wire logic step_subtype_in,
  input wire logic [31:0] ferr_window_in,
  input wire logic [15:0] ferr_timeout_ms_in,
  input wire logic signed [31:0] actual_position_in,
  input wire logic [4:0] input_special_en_in,
  // Pins
  input wire logic [4:0] dig_in,
  input wire logic enc_index_in,
  input wire logic setup_done_in,
  // Results
  output logic signed [31:0] demand_position_out,
  output logic signed [16:0] torque_demand_out,
  output logic setup_start_out,
  output logic setup_ok_out,
  output logic [15:0] status_out
);
  logic [15:0] ctrl_q;
  logic [31:0] outw_q;
  logic [4:0] pin_m_q, pin_s_q, pin_p_q;
  logic [1:0] idx_m_q;
  logic [31:0] cyc_cnt_q, samp_cnt_q;
  logic [31:0] cyc_len;
  logic cyc_tick, samp_tick;
  logic [4:0] in_flt_q;
  logic signed [31:0] step_acc_q;
  logic signed [31:0] demand_q;
  logic [7:0] mode_q;
  logic sync_q, fresh_q, follow_q, ferr_q, idx_q, setup_ok_q, done_q, start_q;
  logic [15:0] ferr_ms_q;
  logic signed [16:0] torque_q;
  logic signed [31:0] perr;
  logic [15:0] tlim;
  logic signed [17:0] tsum;
  logic torque_mode, step_mode, setup_mode;

  assign torque_mode = mode_select_in == MODE_TORQUE && closed_loop_in && setup_ok_q;
  assign step_mode = mode_select_in == MODE_STEPDIR;
  assign setup_mode = mode_select_in == MODE_SETUP;

  // Only the millisecond base is supported; other indices stop the cycle
  assign cyc_len = (interp_index_in == 8'(INTERP_INDEX_MS)) ?
    32'(interp_period_in) * 32'(CYCLE_BASE_CLKS) : 32'h0;
  assign cyc_tick = cyc_len != 32'h0 && cyc_cnt_q >= cyc_len - 32'h1;
  assign samp_tick = samp_cnt_q == 32'(INPUT_SAMPLE_CLKS - 1);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || cyc_tick) cyc_cnt_q <= 32'h0;
    else cyc_cnt_q <= cyc_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || samp_tick) samp_cnt_q <= 32'h0;
    else samp_cnt_q <= samp_cnt_q + 32'h1;
  end

  // Two-stage synchronisers; the pulse stage compares the second flop with a third
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_m_q <= 5'h0;
      pin_s_q <= 5'h0;
      pin_p_q <= 5'h0;
      idx_m_q <= 2'h0;
    end else begin
      pin_m_q <= dig_in;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      idx_m_q <= {idx_m_q[0], enc_index_in};
    end
  end

  // Millisecond sampling acts as the filter for slow inputs
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) in_flt_q <= 5'h0;
    else if (samp_tick) in_flt_q <= pin_s_q;
  end

  // Step pulses bypass the millisecond filter; a 200 ns pulse is 50 clocks
  logic rise1, rise2;
  logic signed [31:0] step_w;
  assign rise1 = pin_s_q[0] && !pin_p_q[0];
  assign rise2 = pin_s_q[1] && !pin_p_q[1];
  assign step_w = (step_den_in == 16'h0) ? 32'sh0 :
    $signed(32'(step_num_in) / 32'(step_den_in));

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !step_mode) begin
      step_acc_q <= 32'sh0;
    end else begin
      logic signed [31:0] inc;
      inc = 32'sh0;
      if (!step_subtype_in) begin
        if (rise1) inc = pin_s_q[1] ? step_w : -step_w;
      end else begin
        if (rise1 && !rise2) inc = -step_w;
        else if (rise2 && !rise1) inc = step_w;
      end
      if (cyc_tick) step_acc_q <= inc;
      else step_acc_q <= step_acc_q + inc;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) demand_q <= 32'sh0;
    else if (step_mode && cyc_tick) demand_q <= demand_q + step_acc_q;
  end

  // Following error timer counts milliseconds out of window
  assign perr = demand_q - actual_position_in;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !(step_mode && closed_loop_in)) begin
      ferr_ms_q <= 16'h0;
      ferr_q <= 1'b0;
    end else if (samp_tick) begin
      if ((perr < 0 ? -perr : perr) > $signed(ferr_window_in)) begin
        if (ferr_ms_q != 16'hffff) ferr_ms_q <= ferr_ms_q + 16'h1;
        ferr_q <= ferr_ms_q >= ferr_timeout_ms_in;
      end else begin
        ferr_ms_q <= 16'h0;
        ferr_q <= 1'b0;
      end
    end
  end

  // Torque path
  assign tlim = (max_torque_in < max_current_in) ? max_torque_in : max_current_in;
  assign tsum = 18'($signed(target_torque_in)) + 18'($signed(torque_offset_in));
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !torque_mode) begin
      torque_q <= 17'sh0;
      fresh_q <= 1'b0;
      sync_q <= 1'b0;
      follow_q <= 1'b0;
    end else begin
      if (target_torque_wr_in) fresh_q <= 1'b1;
      if (cyc_tick) begin
        fresh_q <= target_torque_wr_in;
        sync_q <= fresh_q || target_torque_wr_in;
        follow_q <= 1'b1;
        if (tsum > $signed({2'b00, tlim})) torque_q <= $signed({1'b0, tlim});
        else if (tsum < -$signed({2'b00, tlim})) torque_q <= -$signed({1'b0, tlim});
        else torque_q <= 17'(tsum);
      end
    end
  end

  // Auto-setup
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      start_q <= 1'b0;
      idx_q <= 1'b0;
      done_q <= 1'b0;
      setup_ok_q <= 1'b0;
    end else begin
      start_q <= setup_mode && reg_wr_in && reg_idx_in == REG_CONTROL &&
        reg_wdata_in[CW_START_BIT] && !ctrl_q[CW_START_BIT];
      if (start_q) begin
        idx_q <= 1'b0;
        done_q <= 1'b0;
      end else if (setup_mode) begin
        if (idx_m_q[1]) idx_q <= 1'b1;
        if (setup_done_in) begin
          done_q <= 1'b1;
          setup_ok_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) ctrl_q <= CTRL_RST;
    else if (reg_wr_in && reg_idx_in == REG_CONTROL) ctrl_q <= reg_wdata_in[15:0];
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) outw_q <= OUT_RST;
    else if (reg_wr_in && reg_idx_in == REG_OUTPUTS) outw_q <= reg_wdata_in;
  end

  logic [15:0] st;
  always_comb begin
    st = 16'h0;
    if (torque_mode) begin
      st[ST_SYNC_BIT] = sync_q;
      st[ST_FOLLOW_BIT] = follow_q;
    end else if (step_mode) begin
      st[ST_FERR_BIT] = ferr_q;
    end else if (setup_mode) begin
      st[ST_INDEX_BIT] = idx_q;
      st[ST_FOLLOW_BIT] = done_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 32'h0;
      status_out <= 16'h0;
    end else begin
      status_out <= st;
      if (reg_idx_in == REG_CONTROL) reg_rdata_out <= {16'h0, ctrl_q};
      else if (reg_idx_in == REG_STATUS) reg_rdata_out <= {16'h0, st};
      else if (reg_idx_in == REG_INPUTS)
        reg_rdata_out <= {11'h0, in_flt_q, 11'h0, in_flt_q & input_special_en_in};
      else if (reg_idx_in == REG_OUTPUTS) reg_rdata_out <= outw_q;
      else reg_rdata_out <= 32'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      demand_position_out <= 32'sh0;
      torque_demand_out <= 17'sh0;
      setup_start_out <= 1'b0;
      setup_ok_out <= 1'b0;
    end else begin
      demand_position_out <= demand_q;
      torque_demand_out <= torque_q;
      setup_start_out <= start_q;
      setup_ok_out <= setup_ok_q;
    end
  end

  // Assertions
  property p_torque_gate;
    @(posedge ref_clk_in) disable iff (srst_in)
      !(closed_loop_in && setup_ok_q) |=> torque_q == 17'sh0 || closed_loop_in && setup_ok_q;
  endproperty
  a_torque_gate: assert property (p_torque_gate) else $error("torque without closed loop");
  property p_clamp;
    @(posedge ref_clk_in) disable iff (srst_in)
      torque_mode && cyc_tick |=> torque_q <= $signed({1'b0, $past(tlim)});
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque above limit");
  property p_demand_cycle;
    @(posedge ref_clk_in) disable iff (srst_in)
      !cyc_tick |=> demand_q == $past(demand_q);
  endproperty
  a_demand_cycle: assert property (p_demand_cycle) else $error("demand moved off cycle");
  property p_drop_steps;
    @(posedge ref_clk_in) disable iff (srst_in)
      !step_mode |=> step_acc_q == 32'sh0;
  endproperty
  a_drop_steps: assert property (p_drop_steps) else $error("steps kept after mode exit");
  sequence s_start_edge;
    setup_mode && reg_wr_in && reg_idx_in == REG_CONTROL && reg_wdata_in[CW_START_BIT] && !ctrl_q[CW_START_BIT];
  endsequence
  property p_start;
    @(posedge ref_clk_in) disable iff (srst_in)
      s_start_edge |=> start_q ##1 setup_start_out;
  endproperty
  a_start: assert property (p_start) else $error("setup start missing");
  property p_start_only_edge;
    @(posedge ref_clk_in) disable iff (srst_in)
      start_q |-> $past(ctrl_q[CW_START_BIT]) == 1'b0;
  endproperty
  a_start_only_edge: assert property (p_start_only_edge) else $error("start without edge");
  property p_done;
    @(posedge ref_clk_in) disable iff (srst_in)
      setup_mode && setup_done_in && !start_q |=> done_q && setup_ok_q;
  endproperty
  a_done: assert property (p_done) else $error("setup done not flagged");
  property p_level16;
    @(posedge ref_clk_in) disable iff (srst_in)
      reg_idx_in == REG_INPUTS |=> reg_rdata_out[LEVEL_BASE_BIT] == $past(in_flt_q[0]);
  endproperty
  a_level16: assert property (p_level16) else $error("input 1 level wrong");
  property p_sample;
    @(posedge ref_clk_in) disable iff (srst_in)
      !samp_tick |=> $stable(in_flt_q);
  endproperty
  a_sample: assert property (p_sample) else $error("input sampled off tick");
endmodule // dmts_top

// ===== testbench/dmts_step_source.sv
/*
  Stand-in for the positioning controller that drives in1 and in2.
  Assumes the bench clock at 250 MHz; the bench calls its tasks.
*/
`timescale 1ns/1ps
module dmts_step_source (
  // Clock
  input wire logic clk_in,
  // Pins: bit 0 is in1, bit 1 is in2
  output logic [1:0] pin_out
);
  localparam int HIGH_CLKS = 50;
  localparam int GAP_CLKS = 250;
  localparam int DIR_WAIT_CLKS = 8750;
  logic dir_q = 1'b0;
  initial pin_out = 2'h0;
  // Subtype 0 pulses in1 with sense on in2; subtype 1 pulses in2 up, in1 down
  task automatic send(input logic sub, input logic pos, input int n);
    int line;
    line = (sub && pos) ? 1 : 0;
    if (pos !== dir_q) begin
      dir_q = pos;
      @(posedge clk_in);
      if (!sub) pin_out[1] <= pos;
      repeat (DIR_WAIT_CLKS) @(posedge clk_in);
    end
    repeat (n) begin
      @(posedge clk_in);
      pin_out[line] <= 1'b1;
      repeat (HIGH_CLKS) @(posedge clk_in);
      pin_out[line] <= 1'b0;
      repeat (GAP_CLKS) @(posedge clk_in);
    end
  endtask
  task automatic park(input logic [1:0] lvl);
    @(posedge clk_in);
    pin_out <= lvl;
  endtask
endmodule // dmts_step_source

// ===== testbench/tb.sv
/*
  Bench for dmts_top: registers, both step subtypes, auto-setup, torque
  and the input summary word. Assumes dmts_pkg and the step source.
*/
`timescale 1ns/1ps
module tb import dmts_pkg::*; ;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic [15:0] idx = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic [7:0] mode = 8'h00;
  logic cl = 1'b0;
  logic [15:0] tt = 16'h0000;
  logic tt_wr = 1'b0;
  logic [15:0] tmax = 16'h0000;
  logic [15:0] imax = 16'h0000;
  logic [15:0] toff = 16'h0000;
  logic [15:0] num = STEP_NUM_RST;
  logic [15:0] den = STEP_DEN_RST;
  logic sub = 1'b0;
  logic [4:0] sfen = 5'h00;
  logic [2:0] hi_in = 3'h0;
  logic enc = 1'b0;
  logic done = 1'b0;
  logic signed [31:0] apos = 32'sh0;
  logic [1:0] pins;
  logic [31:0] rdata;
  logic signed [31:0] dpos;
  logic signed [16:0] tq;
  logic start;
  logic ok;
  logic [15:0] st;
  int n_fail = 0;
  int checks = 0;
  dmts_step_source i_src (.clk_in(clk), .pin_out(pins));
  dmts_top i_dut (
    .ref_clk_in(clk), .srst_in(srst), .reg_wr_in(wr), .reg_idx_in(idx),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .mode_select_in(mode),
    .closed_loop_in(cl), .target_torque_in(tt), .target_torque_wr_in(tt_wr),
    .max_torque_in(tmax), .max_current_in(imax), .torque_offset_in(toff),
    .interp_period_in(8'h01), .interp_index_in(8'(INTERP_INDEX_MS)),
    .step_num_in(num), .step_den_in(den), .step_subtype_in(sub),
    .ferr_window_in(32'h0000_0100), .ferr_timeout_ms_in(16'h0005),
    .actual_position_in(apos), .input_special_en_in(sfen),
    .dig_in({hi_in, pins}), .enc_index_in(enc), .setup_done_in(done),
    .demand_position_out(dpos), .torque_demand_out(tq),
    .setup_start_out(start), .setup_ok_out(ok), .status_out(st)
  );
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input bit good, input string what);
    checks++;
    if (!good) begin
      n_fail++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic reg_wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] i, output logic [31:0] d);
    @(posedge clk);
    idx <= i;
    repeat (2) @(posedge clk);
    #1 d = rdata;
  endtask
  // Tick phase is unknown, so allow two full cycles for a result
  task automatic wait_out(input bit torque, input logic signed [31:0] e);
    int k;
    k = 0;
    while ((torque ? {{15{tq[16]}}, tq} : dpos) !== e && k < 600000) begin
      @(posedge clk);
      k++;
    end
    #1 chk((torque ? {{15{tq[16]}}, tq} : dpos) === e, "result value");
  endtask
  task automatic count_starts(output int c);
    c = 0;
    repeat (4) begin
      @(posedge clk);
      #1 if (start === 1'b1) c++;
    end
  endtask
  task automatic tq_set(input logic [15:0] v, input logic [15:0] off);
    @(posedge clk);
    tt <= v;
    toff <= off;
    tt_wr <= 1'b1;
    @(posedge clk);
    tt_wr <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(REG_CONTROL, d);
    chk(d === {16'h0, CTRL_RST}, "control reset");
    reg_wr(REG_OUTPUTS, 32'h0002_0000);
    reg_rd(REG_OUTPUTS, d);
    chk(d === 32'h0002_0000, "output word");
    reg_wr(REG_STATUS, 32'h0000_ffff);
    reg_rd(REG_STATUS, d);
    chk(d === 32'h0, "status write");
    reg_wr(REG_INPUTS, 32'hffff_ffff);
    reg_rd(REG_INPUTS, d);
    chk(d === 32'h0, "input word write");
    reg_rd(16'h1234, d);
    chk(d === 32'h0, "unmapped read");
  endtask
  task automatic t_step0();
    @(posedge clk);
    mode <= MODE_STEPDIR;
    i_src.send(1'b0, 1'b1, 3);
    i_src.send(1'b0, 1'b0, 1);
    wait_out(1'b0, 32'sd256);
    // A pulse left behind when the mode is dropped must not move the demand
    i_src.send(1'b0, 1'b0, 1);
    mode <= 8'h00;
    repeat (20) @(posedge clk);
    mode <= MODE_STEPDIR;
    repeat (260000) @(posedge clk);
    #1 chk(dpos === 32'sd256, "buffer discarded");
  endtask
  task automatic t_step1();
    i_src.park(2'h0);
    sub <= 1'b1;
    num <= 16'h0400;
    den <= 16'h0002;
    i_src.send(1'b1, 1'b1, 2);
    i_src.send(1'b1, 1'b0, 1);
    wait_out(1'b0, 32'sd768);
  endtask
  task automatic t_setup();
    int c;
    @(posedge clk);
    mode <= MODE_SETUP;
    reg_wr(REG_CONTROL, 32'h0000_0010);
    count_starts(c);
    chk(c == 1, "start on rising bit 4");
    reg_wr(REG_CONTROL, 32'h0000_0010);
    count_starts(c);
    chk(c == 0, "no start without edge");
    chk(st[ST_INDEX_BIT] === 1'b0, "index flag idle");
    enc <= 1'b1;
    repeat (10) @(posedge clk);
    enc <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk(st[ST_INDEX_BIT] === 1'b1, "index flag");
    chk(ok === 1'b0, "setup not yet done");
    done <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk(st[ST_FOLLOW_BIT] === 1'b1, "aligned flag");
    chk(ok === 1'b1, "setup ok");
  endtask
  task automatic t_torque();
    logic [31:0] d;
    i_src.park(2'h1);
    hi_in <= 3'h3;
    sfen <= 5'h04;
    repeat (100) @(posedge clk);
    hi_in <= 3'h1;
    mode <= MODE_TORQUE;
    cl <= 1'b1;
    tmax <= 16'd500;
    imax <= 16'd300;
    tq_set(16'd1000, 16'd0);
    wait_out(1'b1, 32'sd300);
    tq_set(16'd100, 16'd20);
    wait_out(1'b1, 32'sd120);
    chk(st[ST_SYNC_BIT] === 1'b1, "sync flag");
    chk(st[ST_FOLLOW_BIT] === 1'b1, "follow flag");
    tq_set(-16'sd1000, 16'd0);
    wait_out(1'b1, -32'sd300);
    reg_rd(REG_INPUTS, d);
    chk(d === 32'h0005_0004, "input summary");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_step0();
    t_step1();
    t_setup();
    t_torque();
    tally_and_finish();
  end
  initial begin
    repeat (4000000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // tb
